// file: verilog/sts_pkg.sv
package sts_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CTRL_CYCLE_NS = 62500;
  // 62.5 us is not a whole number of 40 ns clocks; the cycle is truncated to 1562 clocks
  localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int SPEED_W = 16;

  localparam logic [ADDR_W-1:0] ADR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_STOP_DELAY = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_DWELL = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_ZERO_LIMIT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h10;

  localparam int CFG_MANUAL_BIT = 0;
  localparam int CFG_BRAKE_LSB = 1;
  localparam int CFG_BRAKE_W = 4;
  localparam int CFG_ZCHK_BIT = 5;
  localparam int CFG_W = 6;

  localparam int ST_TORQUE_OFF_BIT = 0;
  localparam int ST_SAFE_STOP_BIT = 1;
  localparam int ST_ACK_REQ_BIT = 2;
  localparam int ST_FAULT_BIT = 3;

  localparam logic [CFG_BRAKE_W-1:0] BRAKE_NONE = 4'h0;
  localparam logic [CFG_BRAKE_W-1:0] BRAKE_MAX = 4'h8;

  localparam logic [CFG_W-1:0] RST_CONFIG = 6'h00;
  localparam logic [CNT_W-1:0] RST_STOP_DELAY = 16'h0010;
  localparam logic [CNT_W-1:0] RST_DWELL = 16'h0000;
  localparam logic [SPEED_W-1:0] RST_ZERO_LIMIT = 16'h0000;

  typedef enum logic [2:0] {
    STS_SS_IDLE = 3'b001,
    STS_SS_RUN = 3'b010,
    STS_SS_HOLD = 3'b100
  } sts_ss_state_type;

  typedef enum logic [2:0] {
    STS_TO_IDLE = 3'b001,
    STS_TO_ACTIVE = 3'b010,
    STS_TO_ACK_WAIT = 3'b100
  } sts_to_state_type;
endpackage

// file: verilog/sts_tick_gen.sv
module sts_tick_gen #(
  parameter int PERIOD = sts_pkg::CTRL_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick_o
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule

// file: verilog/sts_top.sv
// How it works
// - torque-off request removes torque at once and sets torque-off status.
// - automatic restart ends torque-off as soon as the request clears.
// - manual restart holds torque-off until a rising restart-acknowledge edge.
// - acknowledge-request output stays high while a manual restart is pending.
// - torque-off may also close the brake through one of eight instances.
// - torque-off itself never raises any fault.
// - every safe stop ends in torque-off governed by its restart setting.
// - safe-stop trigger starts a timer; at expiry torque-off executes.
// - safe stop requests braking from the drive and sets safe-stop status.
// - with zero check on, speed outside window at expiry flags a fault.
// - safe-stop status stays while pending, clears as torque-off status sets.
// - a triggered safe stop always runs to torque-off, however brief.
// - trigger still held at torque-off keeps torque-off until it drops.
// - trigger gone early with automatic restart gives one-cycle torque-off.
// - trigger gone early with manual restart still needs an acknowledge.
// - dwell monitoring only when dwell count nonzero; window is plus/minus limit.
// - speed must stay in window for the dwell; leaving restarts the count.
// - meeting the dwell ends the safe stop early with torque-off.
// - all timers and checks advance once per fixed control cycle.
//
// Implementation choices: strobed register access and the register addresses.
module sts_top #(
  parameter int CYCLE_CLKS = sts_pkg::CTRL_CYCLE_CLKS,
  parameter int CNT_W = sts_pkg::CNT_W,
  parameter int SPEED_W = sts_pkg::SPEED_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [sts_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sts_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sts_pkg::DATA_W-1:0] reg_rdata,
  input wire logic torque_off_req,
  input wire logic safe_stop_req,
  input wire logic restart_ack,
  input wire logic signed [SPEED_W-1:0] speed,
  output logic torque_enable,
  output logic torque_off_status,
  output logic safe_stop_status,
  output logic restart_ack_request,
  output logic decel_request,
  output logic brake_close,
  output logic [sts_pkg::CFG_BRAKE_W-1:0] brake_instance_select,
  output logic stop_fault
);
  logic rst_meta_r;
  logic rst_n;
  logic tick;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  sts_tick_gen #(.PERIOD(CYCLE_CLKS)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick_o(tick)
  );

  // configuration registers
  logic [sts_pkg::CFG_W-1:0] cfg_r;
  logic [CNT_W-1:0] stop_delay_r;
  logic [CNT_W-1:0] dwell_r;
  logic [SPEED_W-1:0] zero_limit_r;
  logic manual_restart;
  logic zero_check_en;
  logic dwell_en;
  logic [sts_pkg::CFG_BRAKE_W-1:0] brake_sel;

  assign manual_restart = cfg_r[sts_pkg::CFG_MANUAL_BIT];
  assign zero_check_en = cfg_r[sts_pkg::CFG_ZCHK_BIT];
  assign brake_sel = cfg_r[sts_pkg::CFG_BRAKE_LSB +: sts_pkg::CFG_BRAKE_W];
  assign dwell_en = (dwell_r != '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= sts_pkg::RST_CONFIG;
      stop_delay_r <= sts_pkg::RST_STOP_DELAY;
      dwell_r <= sts_pkg::RST_DWELL;
      zero_limit_r <= sts_pkg::RST_ZERO_LIMIT;
    end else if (reg_wr) begin
      case (reg_addr)
        sts_pkg::ADR_CONFIG: cfg_r <= reg_wdata[sts_pkg::CFG_W-1:0];
        sts_pkg::ADR_STOP_DELAY: stop_delay_r <= reg_wdata[CNT_W-1:0];
        sts_pkg::ADR_DWELL: dwell_r <= reg_wdata[CNT_W-1:0];
        sts_pkg::ADR_ZERO_LIMIT: zero_limit_r <= reg_wdata[SPEED_W-1:0];
        default: ;
      endcase
    end
  end

  // edges are caught on every clock so a pulse shorter than a control cycle still counts
  logic ss_req_q_r;
  logic ack_q_r;
  logic ss_pend_r;
  logic ack_pend_r;
  logic ss_edge;
  logic ack_edge;
  sts_pkg::sts_ss_state_type ss_state_r;
  sts_pkg::sts_ss_state_type ss_nxt;
  sts_pkg::sts_to_state_type to_state_r;
  sts_pkg::sts_to_state_type to_nxt;

  assign ss_edge = safe_stop_req & ~ss_req_q_r;
  assign ack_edge = restart_ack & ~ack_q_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_req_q_r <= 1'b0;
      ack_q_r <= 1'b0;
      ss_pend_r <= 1'b0;
      ack_pend_r <= 1'b0;
    end else begin
      ss_req_q_r <= safe_stop_req;
      ack_q_r <= restart_ack;
      // a new edge in the consuming cycle wins over the clear
      // clearing on every tick drops edges seen while a stop already runs
      ss_pend_r <= ss_edge | (ss_pend_r & ~tick);
      ack_pend_r <= ack_edge | (ack_pend_r & ~tick);
    end
  end

  // speed window, one bit wider so the most negative speed folds correctly
  logic [SPEED_W:0] speed_abs;
  logic in_window;
  assign speed_abs = speed[SPEED_W-1] ? (SPEED_W+1)'(-$signed({speed[SPEED_W-1], speed}))
                                      : {1'b0, speed};
  assign in_window = (speed_abs <= {1'b0, zero_limit_r});

  logic [CNT_W-1:0] stop_cnt_r;
  logic [CNT_W-1:0] dwell_cnt_r;
  logic stop_expired;
  logic dwell_met;
  logic window_violation;
  assign stop_expired = ({1'b0, stop_cnt_r} + 1'b1) >= {1'b0, stop_delay_r};
  assign dwell_met = dwell_en & in_window & (({1'b0, dwell_cnt_r} + 1'b1) >= {1'b0, dwell_r});
  assign window_violation = stop_expired & zero_check_en & ~in_window;

  always_comb begin
    ss_nxt = ss_state_r;
    case (ss_state_r)
      sts_pkg::STS_SS_IDLE: begin
        if (ss_pend_r | safe_stop_req) begin
          ss_nxt = sts_pkg::STS_SS_RUN;
        end
      end
      sts_pkg::STS_SS_RUN: begin
        if (stop_expired | dwell_met) begin
          ss_nxt = sts_pkg::STS_SS_HOLD;
        end
      end
      sts_pkg::STS_SS_HOLD: begin
        if (!safe_stop_req) begin
          ss_nxt = sts_pkg::STS_SS_IDLE;
        end
      end
      default: ss_nxt = sts_pkg::STS_SS_IDLE;
    endcase
  end

  logic demand_nxt;
  assign demand_nxt = torque_off_req | (ss_nxt == sts_pkg::STS_SS_HOLD);

  always_comb begin
    to_nxt = to_state_r;
    case (to_state_r)
      sts_pkg::STS_TO_IDLE: begin
        if (demand_nxt) begin
          to_nxt = sts_pkg::STS_TO_ACTIVE;
        end
      end
      sts_pkg::STS_TO_ACTIVE: begin
        if (!demand_nxt) begin
          to_nxt = manual_restart ? sts_pkg::STS_TO_ACK_WAIT : sts_pkg::STS_TO_IDLE;
        end
      end
      sts_pkg::STS_TO_ACK_WAIT: begin
        if (demand_nxt) begin
          to_nxt = sts_pkg::STS_TO_ACTIVE;
        end else if (ack_pend_r | ack_edge) begin
          to_nxt = sts_pkg::STS_TO_IDLE;
        end
      end
      default: to_nxt = sts_pkg::STS_TO_ACTIVE;
    endcase
  end

  // sequencing advances only on the control-cycle tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_state_r <= sts_pkg::STS_SS_IDLE;
      to_state_r <= sts_pkg::STS_TO_IDLE;
    end else if (tick) begin
      ss_state_r <= ss_nxt;
      to_state_r <= to_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_cnt_r <= '0;
      dwell_cnt_r <= '0;
    end else if (tick) begin
      if (ss_state_r == sts_pkg::STS_SS_RUN && ss_nxt == sts_pkg::STS_SS_RUN) begin
        stop_cnt_r <= stop_cnt_r + 1'b1;
        dwell_cnt_r <= in_window ? dwell_cnt_r + 1'b1 : '0;
      end else begin
        stop_cnt_r <= '0;
        dwell_cnt_r <= '0;
      end
    end
  end

  // outputs follow the next state so the torque cut lands in the same edge as the decision
  logic to_on_nxt;
  logic brake_ok;
  assign to_on_nxt = (to_nxt != sts_pkg::STS_TO_IDLE);
  assign brake_ok = (brake_sel != sts_pkg::BRAKE_NONE) && (brake_sel <= sts_pkg::BRAKE_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      torque_enable <= 1'b0;
      torque_off_status <= 1'b0;
      safe_stop_status <= 1'b0;
      restart_ack_request <= 1'b0;
      decel_request <= 1'b0;
      brake_close <= 1'b0;
      brake_instance_select <= sts_pkg::BRAKE_NONE;
    end else if (tick) begin
      torque_enable <= ~to_on_nxt;
      torque_off_status <= to_on_nxt;
      safe_stop_status <= (ss_nxt == sts_pkg::STS_SS_RUN);
      decel_request <= (ss_nxt == sts_pkg::STS_SS_RUN);
      restart_ack_request <= (to_nxt == sts_pkg::STS_TO_ACK_WAIT);
      brake_close <= to_on_nxt & brake_ok;
      brake_instance_select <= brake_ok ? brake_sel : sts_pkg::BRAKE_NONE;
    end
  end

  // fault is raised only by the safe-stop window check, never by torque-off
  logic fault_clr;
  assign fault_clr = reg_wr && (reg_addr == sts_pkg::ADR_STATUS) && reg_wdata[sts_pkg::ST_FAULT_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_fault <= 1'b0;
    end else if (tick && ss_state_r == sts_pkg::STS_SS_RUN && window_violation) begin
      stop_fault <= 1'b1;
    end else if (fault_clr) begin
      stop_fault <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        sts_pkg::ADR_CONFIG: reg_rdata <= {{(sts_pkg::DATA_W-sts_pkg::CFG_W){1'b0}}, cfg_r};
        sts_pkg::ADR_STOP_DELAY: reg_rdata <= {{(sts_pkg::DATA_W-CNT_W){1'b0}}, stop_delay_r};
        sts_pkg::ADR_DWELL: reg_rdata <= {{(sts_pkg::DATA_W-CNT_W){1'b0}}, dwell_r};
        sts_pkg::ADR_ZERO_LIMIT: reg_rdata <= {{(sts_pkg::DATA_W-SPEED_W){1'b0}}, zero_limit_r};
        sts_pkg::ADR_STATUS: reg_rdata <= {28'h0000000, stop_fault, restart_ack_request,
                                           safe_stop_status, torque_off_status};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  a_torque_cut: assert property (@(posedge clk) disable iff (!rst_n)
    tick && torque_off_req |=> torque_off_status && !torque_enable)
    else $error("torque not removed after torque-off request");

  a_auto_release: assert property (@(posedge clk) disable iff (!rst_n)
    tick && to_state_r == sts_pkg::STS_TO_ACTIVE && !manual_restart && !demand_nxt
    |=> torque_enable && !torque_off_status)
    else $error("automatic restart did not release torque-off");

  a_manual_hold: assert property (@(posedge clk) disable iff (!rst_n)
    tick && to_state_r == sts_pkg::STS_TO_ACK_WAIT && !ack_pend_r && !ack_edge
    |=> torque_off_status)
    else $error("manual restart released without acknowledge");

  a_ack_request: assert property (@(posedge clk) disable iff (!rst_n)
    tick && to_state_r == sts_pkg::STS_TO_ACTIVE && manual_restart && !demand_nxt
    |=> restart_ack_request && torque_off_status)
    else $error("acknowledge request missing");

  a_brake_follow: assert property (@(posedge clk) disable iff (!rst_n)
    torque_off_status && brake_instance_select != sts_pkg::BRAKE_NONE |-> brake_close)
    else $error("brake not closed during torque-off");

  a_fault_source: assert property (@(posedge clk) disable iff (!rst_n)
    ss_state_r != sts_pkg::STS_SS_RUN |=> !$rose(stop_fault))
    else $error("fault raised outside safe-stop check");

  a_stop_expiry: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_RUN && stop_expired
    |=> torque_off_status && !safe_stop_status)
    else $error("stop delay expiry did not execute torque-off");

  a_ss_signal: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_IDLE && safe_stop_req
    |=> safe_stop_status && decel_request)
    else $error("safe stop start not signalled");

  a_window_fault: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_RUN && window_violation |=> stop_fault)
    else $error("window violation not flagged");

  a_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_HOLD && !safe_stop_req && !torque_off_req
    && !manual_restart |=> ss_state_r == sts_pkg::STS_SS_IDLE && torque_enable)
    else $error("early-released safe stop held torque-off too long");

  a_dwell_abort: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_RUN && !in_window |=> dwell_cnt_r == '0)
    else $error("dwell count not restarted on window exit");

  a_dwell_early: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_RUN && dwell_met |=> ss_state_r == sts_pkg::STS_SS_HOLD)
    else $error("dwell met without early torque-off");

  a_pending_stop: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_IDLE && ss_pend_r |=> ss_state_r == sts_pkg::STS_SS_RUN)
    else $error("latched safe-stop trigger did not start the stop");

  a_hold_torque: assert property (@(posedge clk) disable iff (!rst_n)
    tick && ss_state_r == sts_pkg::STS_SS_HOLD && safe_stop_req |=> torque_off_status && !torque_enable)
    else $error("torque-off dropped while safe-stop trigger still held");

  a_tick_only: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(torque_enable) && $stable(torque_off_status) && $stable(safe_stop_status))
    else $error("safety outputs changed between control ticks");
endmodule

// file: verification/sts_safety_ctrl_model.sv
module sts_safety_ctrl_model (
  input wire logic clk,
  input wire logic restart_ack_request,
  output logic torque_off_req,
  output logic safe_stop_req,
  output logic restart_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    torque_off_req = 1'h0;
    safe_stop_req = 1'h0;
    restart_ack = 1'h0;
  end
  task automatic drive(input logic to, input logic ss);
    @(posedge clk);
    torque_off_req <= to;
    safe_stop_req <= ss;
  endtask
  // acknowledge only when asked; lag lets a slow operator be played
  task automatic ack(input int lag, output bit ok);
    ok = 1'h0;
    for (int i = 0; i < 400 && !ok; i++) begin
      @(posedge clk);
      ok = restart_ack_request === 1'h1;
    end
    if (ok) begin
      repeat (lag) @(posedge clk);
      restart_ack <= 1'h1;
      repeat (2) @(posedge clk);
      restart_ack <= 1'h0;
    end
  endtask
endmodule

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 4;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [sts_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [sts_pkg::DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [sts_pkg::DATA_W-1:0] reg_rdata;
  logic signed [sts_pkg::SPEED_W-1:0] speed = '0;
  logic torque_off_req, safe_stop_req, restart_ack, torque_enable, torque_off_status;
  logic safe_stop_status, restart_ack_request, decel_request, brake_close, stop_fault;
  logic [sts_pkg::CFG_BRAKE_W-1:0] brake_instance_select;
  int fails = 0;
  int checked = 0;
  logic [31:0] rv;
  int n;
  bit ok;

  sts_top #(.CYCLE_CLKS(CYC)) sts_top_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .torque_off_req(torque_off_req), .safe_stop_req(safe_stop_req), .restart_ack(restart_ack),
    .speed(speed), .torque_enable(torque_enable), .torque_off_status(torque_off_status),
    .safe_stop_status(safe_stop_status), .restart_ack_request(restart_ack_request),
    .decel_request(decel_request), .brake_close(brake_close),
    .brake_instance_select(brake_instance_select), .stop_fault(stop_fault));

  sts_safety_ctrl_model sts_safety_ctrl_model_i (.clk(clk), .restart_ack_request(restart_ack_request),
    .torque_off_req(torque_off_req), .safe_stop_req(safe_stop_req), .restart_ack(restart_ack));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic clks(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic settle;
    clks(3 * CYC);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  task automatic ctl(input logic to, input logic ss);
    sts_safety_ctrl_model_i.drive(to, ss);
  endtask

  task automatic set_speed(input logic [15:0] v);
    @(posedge clk);
    speed <= v;
  endtask

  function automatic logic sel(input int w);
    return w == 0 ? safe_stop_status : torque_off_status;
  endfunction

  // clocks that the chosen status stays high, bounded both ways
  task automatic span(input int w, output int k);
    int i;
    k = 0;
    // step off the edge so a status launched there is seen
    #1;
    for (i = 0; i < 400 && sel(w) !== 1'h1; i++)
      clks(1);
    if (i == 400) begin
      fails++;
      test_done();
    end
    while (sel(w) === 1'h1 && k < 400) begin
      if (w == 0)
        check("decel_request", decel_request, 1'h1);
      k++;
      clks(1);
    end
    if (k == 400) begin
      fails++;
      test_done();
    end
  endtask

  task automatic ack_wait(input int lag);
    sts_safety_ctrl_model_i.ack(lag, ok);
    check("ack_seen", ok, 1'h1);
    if (!ok)
      test_done();
  endtask

  task automatic stop_run(input int d, input bit hold, output int k);
    settle();
    wr(sts_pkg::ADR_STOP_DELAY, 32'(d));
    ctl(1'h0, 1'h1);
    if (!hold)
      ctl(1'h0, 1'h0);
    span(0, k);
    check("torque_off_status", torque_off_status, 1'h1);
    check("torque_enable", torque_enable, 1'h0);
  endtask

  task automatic t_reset;
    rd(sts_pkg::ADR_STOP_DELAY, rv);
    check("stop_delay", rv, 32'h10);
    rd(sts_pkg::ADR_CONFIG, rv);
    check("config", rv, 32'h0);
    rd(8'h20, rv);
    check("unmapped", rv, 32'h0);
    settle();
    check("torque_enable", torque_enable, 1'h1);
  endtask

  task automatic t_torque_off;
    ctl(1'h1, 1'h0);
    settle();
    check("torque_enable", torque_enable, 1'h0);
    check("stop_fault", stop_fault, 1'h0);
    check("brake_close", brake_close, 1'h0);
    rd(sts_pkg::ADR_STATUS, rv);
    check("status", rv, 32'h1);
    ctl(1'h0, 1'h0);
    settle();
    check("torque_enable", torque_enable, 1'h1);
    check("restart_ack_request", restart_ack_request, 1'h0);
  endtask

  task automatic t_brake_manual;
    for (int b = 0; b <= 9; b++) begin
      wr(sts_pkg::ADR_CONFIG, 32'(b * 2 + 1));
      ctl(1'h1, 1'h0);
      settle();
      check("brake_close", brake_close, 32'(b != 0 && b <= sts_pkg::BRAKE_MAX));
      check("brake_instance_select", brake_instance_select, 32'(b <= sts_pkg::BRAKE_MAX ? b : 0));
      ctl(1'h0, 1'h0);
      settle();
      check("torque_enable", torque_enable, 1'h0);
      check("restart_ack_request", restart_ack_request, 1'h1);
      ack_wait(b);
      settle();
      check("torque_enable", torque_enable, 1'h1);
      check("restart_ack_request", restart_ack_request, 1'h0);
    end
    wr(sts_pkg::ADR_CONFIG, 32'h0);
  endtask

  task automatic t_stop_short;
    stop_run(3, 1'b0, n);
    check("stop_clocks", n, 3 * CYC);
    span(1, n);
    check("off_clocks", n, CYC);
    check("torque_enable", torque_enable, 1'h1);
  endtask

  task automatic t_stop_held;
    stop_run(2, 1'b1, n);
    check("stop_clocks", n, 2 * CYC);
    clks(4 * CYC);
    check("torque_off_status", torque_off_status, 1'h1);
    ctl(1'h0, 1'h0);
    settle();
    check("torque_enable", torque_enable, 1'h1);
  endtask

  task automatic t_stop_manual;
    wr(sts_pkg::ADR_CONFIG, 32'h1);
    stop_run(2, 1'b0, n);
    clks(3 * CYC);
    check("torque_off_status", torque_off_status, 1'h1);
    check("restart_ack_request", restart_ack_request, 1'h1);
    ack_wait(0);
    settle();
    check("torque_enable", torque_enable, 1'h1);
    wr(sts_pkg::ADR_CONFIG, 32'h0);
  endtask

  task automatic t_zero_window;
    wr(sts_pkg::ADR_CONFIG, 32'h20);
    wr(sts_pkg::ADR_ZERO_LIMIT, 32'h5);
    set_speed(16'h64);
    stop_run(2, 1'b0, n);
    check("stop_fault", stop_fault, 1'h1);
    rd(sts_pkg::ADR_STATUS, rv);
    check("status_fault", rv[3], 1'h1);
    wr(sts_pkg::ADR_STATUS, 32'h8);
    rd(sts_pkg::ADR_STATUS, rv);
    check("status_fault", rv[3], 1'h0);
    // exactly on the limit counts as inside
    set_speed(16'hfffb);
    stop_run(2, 1'b0, n);
    check("stop_fault", stop_fault, 1'h0);
    wr(sts_pkg::ADR_CONFIG, 32'h0);
  endtask

  task automatic t_dwell;
    wr(sts_pkg::ADR_DWELL, 32'h3);
    set_speed(16'h64);
    // two ticks in, two out: never long enough
    fork
      stop_run(10, 1'b0, n);
      repeat (9) begin
        repeat (2 * CYC) @(posedge clk);
        speed <= (speed == 16'sh64) ? 16'sh3 : 16'sh64;
      end
    join
    check("stop_clocks", n, 10 * CYC);
    set_speed(16'h3);
    stop_run(10, 1'b0, n);
    check("early_stop", n, 3 * CYC);
    wr(sts_pkg::ADR_DWELL, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    check("torque_enable", torque_enable, 1'h0);
    rstn <= 1'h1;
    clks(3);
    t_reset();
    t_torque_off();
    t_brake_manual();
    t_stop_short();
    t_stop_held();
    t_stop_manual();
    t_zero_window();
    t_dwell();
    test_done();
  end
endmodule
